//--- hw/mie_defines.svh
// Constants for the instruction execute core: encodings, vectors, reset values
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

// Instruction classes, bits [13:12]
`define MIE_CLS_FILE      2'h0
`define MIE_CLS_BIT       2'h1
`define MIE_CLS_JUMP      2'h2
`define MIE_CLS_LIT       2'h3

// Field positions
`define MIE_CLS_HI        13
`define MIE_CLS_LO        12
`define MIE_OP_HI         11
`define MIE_OP_LO         8
`define MIE_DEST_BIT      7
`define MIE_BOP_HI        11
`define MIE_BOP_LO        10
`define MIE_BSEL_HI       9
`define MIE_BSEL_LO       7
`define MIE_JGOTO_BIT     11

// File class operations
`define MIE_FOP_IOR       4'h0
`define MIE_FOP_XOR       4'h1
`define MIE_FOP_RLF       4'h2
`define MIE_FOP_RRF       4'h3
`define MIE_FOP_SUBC      4'h4

// Bit class operations
`define MIE_BOP_CLR       2'h0
`define MIE_BOP_SET       2'h1
`define MIE_BOP_SKC       2'h2
`define MIE_BOP_SKS       2'h3

// Literal / control class operations
`define MIE_LOP_ADD       4'h0
`define MIE_LOP_SUB       4'h1
`define MIE_LOP_AND       4'h2
`define MIE_LOP_IOR       4'h3
`define MIE_LOP_XOR       4'h4
`define MIE_LOP_MOV       4'h5
`define MIE_LOP_RETURN_WITH_LITERAL     4'h6
`define MIE_LOP_RET       4'h7
`define MIE_LOP_RETURN_FROM_INTERRUPT    4'h8
`define MIE_LOP_ADDPC     4'h9
`define MIE_LOP_SLEEP     4'ha

// Vectors and reset values
`define MIE_RESET_VEC     10'h000
`define MIE_IRQ_VEC       10'h004
`define MIE_RST_BYTE      8'h00
`define MIE_RST_GIE       1'b0

// Software register port
`define MIE_REG_STATUS    2'h0
`define MIE_REG_CTRL      2'h1
`define MIE_ST_Z          0
`define MIE_ST_C          1
`define MIE_ST_DC         2
`define MIE_ST_PD         3
`define MIE_CT_GIE        0

`endif

//--- hw/mie_pkg.sv
// Types shared by the instruction execute core and its ALU
package mie_pkg;

  typedef logic [9:0]  mie_pc_t;
  typedef logic [7:0]  mie_byte_t;
  typedef logic [13:0] mie_instr_t;
  typedef logic [6:0]  mie_faddr_t;

  // Gray sequence: exec -> flush -> exec, sleep one step from flush
  typedef enum logic [1:0] {
    MIE_EXEC  = 2'b00,
    MIE_FLUSH = 2'b01,
    MIE_SLEEP = 2'b11
  } mie_state_t;

  typedef enum logic [3:0] {
    MIE_ALU_OR   = 4'h0,
    MIE_ALU_XOR  = 4'h1,
    MIE_ALU_AND  = 4'h2,
    MIE_ALU_RLF  = 4'h3,
    MIE_ALU_RRF  = 4'h4,
    MIE_ALU_ADD  = 4'h5,
    MIE_ALU_SUBC = 4'h6,
    MIE_ALU_SUB  = 4'h7,
    MIE_ALU_PASS = 4'h8,
    MIE_ALU_BSET = 4'h9,
    MIE_ALU_BCLR = 4'ha
  } mie_alu_op_t;

  typedef struct packed {
    mie_pc_t    pc;
    mie_byte_t  acc;
    logic       carry;
    logic       zero;
    logic       dcarry;
    logic       pd;
    logic       global_irq_enable;
    mie_state_t st;
    mie_byte_t  rdata;
  } mie_core_state_t;

endpackage : mie_pkg

//--- hw/mie_alu.sv
// Eight-bit ALU: logic, rotates through carry, add/subtract, bit force
module mie_alu
  import mie_pkg::*;
(
  input  wire mie_pkg::mie_alu_op_t op_i,
  input  wire mie_pkg::mie_byte_t   opa_i,
  input  wire mie_pkg::mie_byte_t   acc_i,
  input  wire logic                 carry_i,
  input  wire logic [2:0]           bsel_i,
  output mie_pkg::mie_byte_t        res_o,
  output logic                      carry_o,
  output logic                      dcarry_o,
  output logic                      zero_o
);

  logic [7:0] addend;
  logic       cin;
  logic [4:0] low_sum;
  logic [4:0] high_sum;
  logic [7:0] bmask;

  // Subtraction is addition of the inverted accumulator; carry means no borrow
  always_comb
  begin
    addend   = (op_i == MIE_ALU_ADD) ? acc_i : ~acc_i;
    cin      = (op_i == MIE_ALU_SUBC) ? carry_i : (op_i == MIE_ALU_SUB);
    low_sum  = {1'b0, opa_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    high_sum = {1'b0, opa_i[7:4]} + {1'b0, addend[7:4]} + {4'h0, low_sum[4]};
    bmask    = 8'h01 << bsel_i;
    dcarry_o = low_sum[4];                                   // RQ24
    carry_o  = high_sum[4];                                  // RQ24
    res_o    = {high_sum[3:0], low_sum[3:0]};
    case (op_i)
      MIE_ALU_OR:   res_o = opa_i | acc_i;
      MIE_ALU_XOR:  res_o = opa_i ^ acc_i;
      MIE_ALU_AND:  res_o = opa_i & acc_i;
      MIE_ALU_RLF:                                           // RQ4
      begin
        res_o   = {opa_i[6:0], carry_i};
        carry_o = opa_i[7];
      end
      MIE_ALU_RRF:                                           // RQ5
      begin
        res_o   = {carry_i, opa_i[7:1]};
        carry_o = opa_i[0];
      end
      MIE_ALU_PASS: res_o = opa_i;
      MIE_ALU_BSET: res_o = opa_i | bmask;                   // RQ19
      MIE_ALU_BCLR: res_o = opa_i & ~bmask;                  // RQ19
      default:      res_o = {high_sum[3:0], low_sum[3:0]};
    endcase
    zero_o = (res_o == 8'h00);                               // RQ24
  end

endmodule : mie_alu

//--- hw/mie_core.sv
// Instruction execute core: decode, flags, program flow, sleep
//
// The implementer's own choices: the register addresses and the strobed register port.
`include "mie_defines.svh"

//Function
// RQ1 - OR accumulator with file f into destination, zero flag only.
// RQ2 - Destination bit 0 writes accumulator, 1 writes file f.
// RQ3 - XOR accumulator with file f into destination, zero flag only.
// RQ4 - Rotate f left through carry; carry is the only flag changed.
// RQ5 - Rotate f right through carry; carry is the only flag changed.
// RQ6 - f plus inverted accumulator plus carry; updates digit carry, carry, zero.
// RQ7 - Add literal to accumulator; updates digit carry, carry, zero.
// RQ8 - Literal plus inverted accumulator plus one into accumulator; all arithmetic flags.
// RQ9 - AND/OR/XOR literal into accumulator; zero flag only.
// RQ10 - Load literal into accumulator, no flag change.
// RQ11 - Literal to accumulator, program counter from stack top, then pop.
// RQ12 - Call pushes incremented program counter, then jumps to target.
// RQ13 - Goto loads its address field, flags untouched.
// RQ14 - Return reloads program counter from stack top, then pops.
// RQ15 - Interrupt return pops program counter and sets global interrupt enable.
// RQ16 - Program counter becomes incremented value plus accumulator; program keeps accumulator low. The code adds the accumulator sign-extended.
// RQ17 - Sleep stops oscillator, sets power-down flag, wakes on external interrupt.
// RQ18 - Program clears interrupt flags before sleep and follows it with no-op.
// RQ19 - Bit set/clear forces one bit of f, flags unchanged.
// RQ20 - Bit test skip discards next instruction when condition met, two cycles.
// RQ21 - Flow changes take two cycles, skips one or two, others one.
// RQ22 - Ten-bit program counter, reset vector zero, interrupt vector 0004h.
// RQ23 - File address covers 00h to 7Fh, bit select 0 to 7.
// RQ24 - Digit carry from bit 3, carry means no borrow, zero on result zero.
module mie_core
  import mie_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  output mie_pkg::mie_pc_t         pm_addr_o,
  input  wire mie_pkg::mie_instr_t pm_data_i,
  output mie_pkg::mie_faddr_t      dm_addr_o,
  input  wire mie_pkg::mie_byte_t  dm_rdata_i,
  output mie_pkg::mie_byte_t       dm_wdata_o,
  output logic                     dm_we_o,
  output logic                     stk_push_o,
  output logic                     stk_pop_o,
  output mie_pkg::mie_pc_t         stk_wdata_o,
  input  wire mie_pkg::mie_pc_t    stk_top_i,
  input  wire logic                irq_req_i,
  input  wire logic                wake_i,
  output logic                     osc_stop_o,
  output mie_pkg::mie_byte_t       acc_o,
  output logic                     carry_o,
  output logic                     zero_o,
  output logic                     digit_carry_o,
  output logic                     power_down_o,
  output logic                     gie_o,
  input  wire logic [1:0]          reg_addr_i,
  input  wire mie_pkg::mie_byte_t  reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output mie_pkg::mie_byte_t       reg_rdata_o
);

  import mie_pkg::*;

  // Registered state, its next value and decode wires
  mie_core_state_t cur;
  mie_core_state_t next_cur;
  mie_alu_op_t     alu_op;
  mie_byte_t       alu_a;
  mie_byte_t       alu_res;
  logic            alu_c;
  logic            alu_dc;
  logic            alu_z;
  logic [1:0]      cls;
  logic [3:0]      op;
  logic [1:0]      bop;
  logic [2:0]      bsel;
  logic            dest_f;
  logic            bit_val;
  mie_pc_t         pc_inc;

  // Instruction fields
  assign cls     = pm_data_i[`MIE_CLS_HI:`MIE_CLS_LO];
  assign op      = pm_data_i[`MIE_OP_HI:`MIE_OP_LO];
  assign bop     = pm_data_i[`MIE_BOP_HI:`MIE_BOP_LO];
  assign bsel    = pm_data_i[`MIE_BSEL_HI:`MIE_BSEL_LO];    // RQ23
  assign dest_f  = pm_data_i[`MIE_DEST_BIT];
  assign bit_val = dm_rdata_i[bsel];
  assign pc_inc  = cur.pc + 10'h001;

  // Seven-bit file address reaches the whole 00h..7Fh space
  assign dm_addr_o = pm_data_i[6:0];                        // RQ23

  // Operand select: literal field for the literal class, else file data
  always_comb
  begin
    alu_a  = (cls == `MIE_CLS_LIT) ? pm_data_i[7:0] : dm_rdata_i;
    alu_op = MIE_ALU_PASS;
    case (cls)
      `MIE_CLS_FILE:
      begin
        case (op)
          `MIE_FOP_IOR:  alu_op = MIE_ALU_OR;
          `MIE_FOP_XOR:  alu_op = MIE_ALU_XOR;
          `MIE_FOP_RLF:  alu_op = MIE_ALU_RLF;
          `MIE_FOP_RRF:  alu_op = MIE_ALU_RRF;
          `MIE_FOP_SUBC: alu_op = MIE_ALU_SUBC;
          default:       alu_op = MIE_ALU_PASS;
        endcase
      end
      `MIE_CLS_BIT:
        alu_op = (bop == `MIE_BOP_SET) ? MIE_ALU_BSET : MIE_ALU_BCLR;
      `MIE_CLS_LIT:
      begin
        case (op)
          `MIE_LOP_ADD: alu_op = MIE_ALU_ADD;
          `MIE_LOP_SUB: alu_op = MIE_ALU_SUB;
          `MIE_LOP_AND: alu_op = MIE_ALU_AND;
          `MIE_LOP_IOR: alu_op = MIE_ALU_OR;
          `MIE_LOP_XOR: alu_op = MIE_ALU_XOR;
          default:      alu_op = MIE_ALU_PASS;
        endcase
      end
      default: alu_op = MIE_ALU_PASS;
    endcase
  end

  // One shared ALU; each instruction keeps only its own flags
  mie_alu u_alu (
    .op_i     (alu_op),
    .opa_i    (alu_a),
    .acc_i    (cur.acc),
    .carry_i  (cur.carry),
    .bsel_i   (bsel),
    .res_o    (alu_res),
    .carry_o  (alu_c),
    .dcarry_o (alu_dc),
    .zero_o   (alu_z)
  );

  // Next state and memory/stack strobes
  always_comb
  begin
    next_cur    = cur;
    dm_we_o     = 1'b0;
    dm_wdata_o  = alu_res;
    stk_push_o  = 1'b0;
    stk_pop_o   = 1'b0;
    stk_wdata_o = pc_inc;

    // Software writes first so that a hardware update in the same cycle wins
    if (reg_wr_i && reg_addr_i == `MIE_REG_STATUS)
    begin
      next_cur.zero   = reg_wdata_i[`MIE_ST_Z];
      next_cur.carry  = reg_wdata_i[`MIE_ST_C];
      next_cur.dcarry = reg_wdata_i[`MIE_ST_DC];
      next_cur.pd     = cur.pd & reg_wdata_i[`MIE_ST_PD];
    end
    if (reg_wr_i && reg_addr_i == `MIE_REG_CTRL)
      next_cur.global_irq_enable = reg_wdata_i[`MIE_CT_GIE];

    // Read data stands for the one cycle after the strobe only
    next_cur.rdata = 8'h00;
    if (reg_rd_i && reg_addr_i == `MIE_REG_STATUS)
      next_cur.rdata = {4'h0, cur.pd, cur.dcarry, cur.carry, cur.zero};
    else if (reg_rd_i && reg_addr_i == `MIE_REG_CTRL)
      next_cur.rdata = {7'h00, cur.global_irq_enable};

    // One word per cycle in exec, none in flush or sleep
    case (cur.st)
      MIE_EXEC:
      begin
        next_cur.pc = pc_inc;
        // Interrupts only between words, never in a dead cycle
        if (irq_req_i && cur.global_irq_enable)
        begin
          // Taken before the fetched word; it is retried on return
          stk_push_o  = 1'b1;
          stk_wdata_o = cur.pc;
          next_cur.pc  = `MIE_IRQ_VEC;                       // RQ22
          next_cur.global_irq_enable = 1'b0;
          next_cur.st  = MIE_FLUSH;
        end
        else
        begin
          case (cls)
            // File class: destination bit picks memory or accumulator
            `MIE_CLS_FILE:
            begin
              if (op <= `MIE_FOP_SUBC)
              begin
                // Destination select
                if (dest_f)                                   // RQ2
                  dm_we_o = 1'b1;
                else
                  next_cur.acc = alu_res;
                case (op)
                  `MIE_FOP_IOR,
                  `MIE_FOP_XOR:                               // RQ1 RQ3
                    next_cur.zero = alu_z;
                  `MIE_FOP_RLF,
                  `MIE_FOP_RRF:                               // RQ4 RQ5
                    next_cur.carry = alu_c;
                  default:                                    // RQ6
                  begin
                    next_cur.carry  = alu_c;
                    next_cur.dcarry = alu_dc;
                    next_cur.zero   = alu_z;
                  end
                endcase
              end
            end

            // Bit force writes back; a taken skip costs a dead cycle
            `MIE_CLS_BIT:
            begin
              if (bop == `MIE_BOP_CLR || bop == `MIE_BOP_SET)
                dm_we_o = 1'b1;                               // RQ19
              else if ((bop == `MIE_BOP_SKC && !bit_val) ||
                       (bop == `MIE_BOP_SKS && bit_val))
              begin
                // Step over the discarded word, then one idle cycle
                next_cur.pc = cur.pc + 10'h002;               // RQ20
                next_cur.st = MIE_FLUSH;                      // RQ21
              end
            end

            // Call and goto share the target field; only call pushes
            `MIE_CLS_JUMP:
            begin
              if (!pm_data_i[`MIE_JGOTO_BIT])
                stk_push_o = 1'b1;                            // RQ12
              next_cur.pc = pm_data_i[9:0];                   // RQ12 RQ13
              next_cur.st = MIE_FLUSH;                        // RQ21
            end

            // Literal class: arithmetic, logic, returns, jumps, sleep
            default:
            begin
              case (op)
                `MIE_LOP_ADD,
                `MIE_LOP_SUB:                                 // RQ7 RQ8
                begin
                  next_cur.acc    = alu_res;
                  next_cur.carry  = alu_c;
                  next_cur.dcarry = alu_dc;
                  next_cur.zero   = alu_z;
                end
                // Bitwise forms leave carry and digit carry alone
                `MIE_LOP_AND,
                `MIE_LOP_IOR,
                `MIE_LOP_XOR:                                 // RQ9
                begin
                  next_cur.acc  = alu_res;
                  next_cur.zero = alu_z;
                end

                `MIE_LOP_MOV:
                  next_cur.acc = pm_data_i[7:0];              // RQ10
                // Returns read the top entry before the stack pops
                `MIE_LOP_RETURN_WITH_LITERAL:
                begin
                  next_cur.acc = pm_data_i[7:0];              // RQ11
                  next_cur.pc  = stk_top_i;
                  stk_pop_o    = 1'b1;
                  next_cur.st  = MIE_FLUSH;
                end

                `MIE_LOP_RET:
                begin
                  next_cur.pc = stk_top_i;                    // RQ14
                  stk_pop_o   = 1'b1;
                  next_cur.st = MIE_FLUSH;
                end

                `MIE_LOP_RETURN_FROM_INTERRUPT:
                begin
                  next_cur.pc  = stk_top_i;                   // RQ15
                  stk_pop_o    = 1'b1;
                  next_cur.global_irq_enable = 1'b1;
                  next_cur.st  = MIE_FLUSH;
                end

                `MIE_LOP_ADDPC:
                begin
                  // Accumulator is sign-extended; below 80h it adds as is
                  next_cur.pc = pc_inc + {{2{cur.acc[7]}}, cur.acc}; // RQ16
                  next_cur.st = MIE_FLUSH;                    // RQ21
                end

                `MIE_LOP_SLEEP:
                begin
                  next_cur.pd = 1'b1;                         // RQ17
                  next_cur.st = MIE_SLEEP;
                end
                default:
                  next_cur.st = MIE_EXEC;
              endcase
            end
          endcase
        end
      end

      // Dead cycle: the word fetched behind a flow change is dropped
      MIE_FLUSH:
        next_cur.st = MIE_EXEC;                               // RQ21

      MIE_SLEEP:
      begin
        // Program counter already points past the sleep word
        if (wake_i)
          next_cur.st = MIE_EXEC;                             // RQ17
      end
      default:
        next_cur.st = MIE_EXEC;
    endcase
  end

  // State register; program starts at the reset vector
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cur.pc     <= `MIE_RESET_VEC;                           // RQ22
      cur.acc    <= `MIE_RST_BYTE;
      cur.carry  <= 1'b0;
      cur.zero   <= 1'b0;
      cur.dcarry <= 1'b0;
      cur.pd     <= 1'b0;
      cur.global_irq_enable    <= `MIE_RST_GIE;
      cur.st     <= MIE_EXEC;
      cur.rdata  <= `MIE_RST_BYTE;
    end
    else
      cur <= next_cur;
  end

  // Outputs straight from state
  assign pm_addr_o     = cur.pc;
  assign osc_stop_o    = (cur.st == MIE_SLEEP);               // RQ17
  assign acc_o         = cur.acc;
  assign carry_o       = cur.carry;
  assign zero_o        = cur.zero;
  assign digit_carry_o = cur.dcarry;
  assign power_down_o  = cur.pd;
  assign gie_o         = cur.global_irq_enable;
  assign reg_rdata_o   = cur.rdata;

endmodule : mie_core

//--- verification/mie_core_sva.sv
// Concurrent checks on the execute core ports
`include "mie_defines.svh"
module mie_core_sva
(
  input wire logic                sys_clk_i,
  input wire logic                rst_n_i,
  input wire mie_pkg::mie_pc_t    pm_addr_o,
  input wire mie_pkg::mie_instr_t pm_data_i,
  input wire mie_pkg::mie_faddr_t dm_addr_o,
  input wire mie_pkg::mie_byte_t  dm_rdata_i,
  input wire mie_pkg::mie_byte_t  dm_wdata_o,
  input wire logic                dm_we_o,
  input wire logic                stk_push_o,
  input wire logic                stk_pop_o,
  input wire mie_pkg::mie_pc_t    stk_wdata_o,
  input wire mie_pkg::mie_pc_t    stk_top_i,
  input wire logic                irq_req_i,
  input wire logic                wake_i,
  input wire logic                osc_stop_o,
  input wire mie_pkg::mie_byte_t  acc_o,
  input wire logic                power_down_o,
  input wire logic                gie_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mie_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Flow changes: push value, target, pop target, dead flush cycle
  call_push_a: assert property (
    stk_push_o && pm_data_i[13:11] == 3'b100 && !(irq_req_i && gie_o)
    |-> stk_wdata_o == pm_addr_o + 10'h001 ##1 pm_addr_o == $past(pm_data_i[9:0]))
    else $error("call push value or target wrong");
  ret_pop_a: assert property (
    stk_pop_o |=> pm_addr_o == $past(stk_top_i)) else $error("return target wrong");
  flush_idle_a: assert property (
    stk_pop_o |=> !stk_push_o && !stk_pop_o && !dm_we_o) else $error("flush cycle acted");
  return_from_interrupt_gie_a: assert property (
    stk_pop_o && pm_data_i[13:8] == {`MIE_CLS_LIT, `MIE_LOP_RETURN_FROM_INTERRUPT} |=> gie_o)
    else $error("interrupt return left enable low");
  return_with_literal_acc_a: assert property (
    stk_pop_o && pm_data_i[13:8] == {`MIE_CLS_LIT, `MIE_LOP_RETURN_WITH_LITERAL}
    |=> acc_o == $past(pm_data_i[7:0])) else $error("literal return value wrong");
  // Bit force touches only the chosen bit
  bit_force_a: assert property (
    dm_we_o && pm_data_i[13:11] == {`MIE_CLS_BIT, 1'b0}
    |-> ((dm_wdata_o ^ dm_rdata_i) & ~(8'h01 << pm_data_i[9:7])) == 8'h00
    && dm_wdata_o[pm_data_i[9:7]] == pm_data_i[10]) else $error("bit force wrong");
  file_dest_a: assert property (
    dm_we_o |-> dm_addr_o == pm_data_i[6:0] && !pm_data_i[13]
    && (pm_data_i[12] || pm_data_i[7])) else $error("memory write not allowed");
  sleep_hold_a: assert property (
    osc_stop_o && !wake_i |=> osc_stop_o && power_down_o) else $error("sleep left early");
  irq_vec_a: assert property (
    stk_push_o && irq_req_i && gie_o |=> pm_addr_o == `MIE_IRQ_VEC && !gie_o)
    else $error("interrupt entry wrong");
  // Reset itself is the antecedent, so no disable here
  reset_vec_a: assert property (disable iff (1'b0)
    !rst_n_i |=> pm_addr_o == `MIE_RESET_VEC && acc_o == 8'h00 && !gie_o)
    else $error("reset state wrong");
  cover property (stk_pop_o);
  cover property (osc_stop_o);
  cover property (dm_we_o && pm_data_i[13:12] == `MIE_CLS_BIT);
endmodule : mie_core_sva

bind mie_core mie_core_sva u_sva (
  .sys_clk_i, .rst_n_i, .pm_addr_o, .pm_data_i, .dm_addr_o, .dm_rdata_i,
  .dm_wdata_o, .dm_we_o, .stk_push_o, .stk_pop_o, .stk_wdata_o, .stk_top_i,
  .irq_req_i, .wake_i, .osc_stop_o, .acc_o, .power_down_o, .gie_o
);

//--- verification/mie_mem_model.sv
// Program memory, data memory and return stack beside the core
module mie_mem_model
(
  input  wire logic                sys_clk_i,
  input  wire mie_pkg::mie_pc_t    pm_addr_i,
  output mie_pkg::mie_instr_t      pm_data_o,
  input  wire mie_pkg::mie_faddr_t dm_addr_i,
  output mie_pkg::mie_byte_t       dm_rdata_o,
  input  wire mie_pkg::mie_byte_t  dm_wdata_i,
  input  wire logic                dm_we_i,
  input  wire logic                stk_push_i,
  input  wire logic                stk_pop_i,
  input  wire mie_pkg::mie_pc_t    stk_wdata_i,
  output mie_pkg::mie_pc_t         stk_top_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import mie_pkg::*;
  mie_instr_t pm [1024];
  mie_byte_t  dm [128];
  mie_pc_t    stk [8];
  int         sp = 0;
  // Unused words are no-ops so stray fetches do nothing
  initial foreach (pm[i]) pm[i] = 14'h3f00;
  initial foreach (dm[i]) dm[i] = 8'h00;
  // Async reads; an empty stack shows a pattern, never a stale address
  assign pm_data_o  = pm[pm_addr_i];
  assign dm_rdata_o = dm[dm_addr_i];
  assign stk_top_o  = (sp == 0) ? 10'h2aa : stk[sp - 1];
  // Writes and stack moves land at the edge
  always @(posedge sys_clk_i)
  begin
    if (dm_we_i) dm[dm_addr_i] <= dm_wdata_i;
    if (stk_push_i) stk[sp] <= stk_wdata_i;
    sp <= sp + int'(stk_push_i) - int'(stk_pop_i);
  end
endmodule : mie_mem_model

//--- verification/mie_core_tb.sv
// Self-checking bench for the instruction execute core
`include "mie_defines.svh"
module mie_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mie_pkg::*;
  logic       sys_clk_i = 1'b0, rst_n_i = 1'b0, irq_req_i = 1'b0, wake_i = 1'b0;
  logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [1:0] reg_addr_i = 2'h0;
  mie_byte_t  reg_wdata_i = 8'h00, reg_rdata_o, dm_rdata_i, dm_wdata_o, acc_o;
  mie_pc_t    pm_addr_o, stk_wdata_o, stk_top_i;
  mie_instr_t pm_data_i;
  mie_faddr_t dm_addr_o;
  logic       dm_we_o, stk_push_o, stk_pop_o, osc_stop_o, carry_o, zero_o;
  logic       digit_carry_o, power_down_o, gie_o;
  int         n_errors = 0, n_compared = 0;

  mie_core DUT (.sys_clk_i, .rst_n_i, .pm_addr_o, .pm_data_i, .dm_addr_o, .dm_rdata_i,
    .dm_wdata_o, .dm_we_o, .stk_push_o, .stk_pop_o, .stk_wdata_o, .stk_top_i, .irq_req_i,
    .wake_i, .osc_stop_o, .acc_o, .carry_o, .zero_o, .digit_carry_o, .power_down_o,
    .gie_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  mie_mem_model mem (.sys_clk_i, .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i),
    .dm_addr_i(dm_addr_o), .dm_rdata_o(dm_rdata_i), .dm_wdata_i(dm_wdata_o),
    .dm_we_i(dm_we_o), .stk_push_i(stk_push_o), .stk_pop_i(stk_pop_o),
    .stk_wdata_i(stk_wdata_o), .stk_top_o(stk_top_i));

  // Encoders for the literal, file and bit classes; jump words are built inline
  function automatic mie_instr_t lit_w(input logic [3:0] op, input mie_byte_t k);
    return {`MIE_CLS_LIT, op, k};
  endfunction : lit_w
  function automatic mie_instr_t file_w(input logic [3:0] op, input logic d, input mie_faddr_t f);
    return {`MIE_CLS_FILE, op, d, f};
  endfunction : file_w
  function automatic mie_instr_t bit_w(input logic [1:0] op, input logic [2:0] b,
    input mie_faddr_t f);
    return {`MIE_CLS_BIT, op, b, f};
  endfunction : bit_w

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Run until the fetch reaches a, bounded so a lost branch cannot hang
  task automatic at(input mie_pc_t a);
    for (int i = 0; i < 300 && pm_addr_o !== a; i++)
      @(posedge sys_clk_i) #1;
    check(pm_addr_o, a);
  endtask : at
  task automatic ac(input mie_pc_t a, input logic [10:0] e);
    at(a);
    check({acc_o, carry_o, digit_carry_o, zero_o}, e);
  endtask : ac
  task automatic reg_xfer(input logic wr, input logic [1:0] a, input mie_byte_t d);
    @(posedge sys_clk_i);
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    if (!wr) check(reg_rdata_o, d);
  endtask : reg_xfer
  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  // Watchdog well beyond the few dozen cycles the program needs
  initial
  begin
    #50000;
    n_errors++;
    give_verdict();
  end
  // Program loaded during reset, after the model has cleared its arrays
  initial
  begin
    #1;
    mem.dm[7'h40] = 8'h81;
    mem.dm[7'h41] = 8'h02;
    mem.pm[0] = {`MIE_CLS_JUMP, 2'b10, 10'h008};
    mem.pm[4] = lit_w(`MIE_LOP_RETURN_FROM_INTERRUPT, 8'h00);
    mem.pm[8] = lit_w(`MIE_LOP_MOV, 8'h0f);
    mem.pm[9] = lit_w(`MIE_LOP_ADD, 8'hf1);
    mem.pm[10] = lit_w(`MIE_LOP_SUB, 8'h05);
    mem.pm[11] = lit_w(`MIE_LOP_SUB, 8'h03);
    mem.pm[12] = file_w(`MIE_FOP_IOR, 1'b1, 7'h40);
    mem.pm[13] = file_w(`MIE_FOP_XOR, 1'b0, 7'h40);
    mem.pm[14] = file_w(`MIE_FOP_RLF, 1'b0, 7'h40);
    mem.pm[15] = file_w(`MIE_FOP_RRF, 1'b1, 7'h41);
    mem.pm[16] = file_w(`MIE_FOP_SUBC, 1'b0, 7'h41);
    mem.pm[17] = lit_w(`MIE_LOP_AND, 8'h00);
    mem.pm[18] = lit_w(`MIE_LOP_XOR, 8'h5a);
    mem.pm[19] = lit_w(`MIE_LOP_IOR, 8'h81);
    mem.pm[20] = lit_w(`MIE_LOP_MOV, 8'h00);
    mem.pm[21] = bit_w(`MIE_BOP_SET, 3'h7, 7'h42);
    mem.pm[22] = bit_w(`MIE_BOP_CLR, 3'h0, 7'h40);
    mem.pm[23] = bit_w(`MIE_BOP_SKC, 3'h7, 7'h42);
    mem.pm[24] = bit_w(`MIE_BOP_SKS, 3'h7, 7'h42);
    mem.pm[25] = lit_w(`MIE_LOP_MOV, 8'hee);
    mem.pm[26] = bit_w(`MIE_BOP_SKC, 3'h0, 7'h40);
    mem.pm[27] = lit_w(`MIE_LOP_MOV, 8'hee);
    mem.pm[28] = {`MIE_CLS_JUMP, 2'b00, 10'h028};
    mem.pm[40] = {`MIE_CLS_JUMP, 2'b00, 10'h02a};
    mem.pm[41] = lit_w(`MIE_LOP_RETURN_WITH_LITERAL, 8'h33);
    mem.pm[42] = lit_w(`MIE_LOP_RET, 8'h00);
    mem.pm[29] = lit_w(`MIE_LOP_MOV, 8'h10);
    mem.pm[30] = lit_w(`MIE_LOP_ADDPC, 8'h00);
    mem.pm[31] = lit_w(`MIE_LOP_MOV, 8'hee);
    mem.pm[47] = lit_w(`MIE_LOP_SLEEP, 8'h00);
    mem.pm[48] = 14'h3f00;
    mem.pm[49] = {`MIE_CLS_JUMP, 2'b10, 10'h031};
  end
  // Main sequence: reset, program walk, sleep, registers, interrupt
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1 check(pm_addr_o, `MIE_RESET_VEC);
    ac(10, {8'h00, 3'b111});
    ac(11, {8'h05, 3'b110});
    ac(12, {8'hfe, 3'b000});
    ac(14, {8'h01, 3'b000});
    ac(15, {8'hfe, 3'b100});
    ac(16, {8'hfe, 3'b000});
    ac(17, {8'h82, 3'b000});
    ac(18, {8'h00, 3'b001});
    ac(20, {8'hdb, 3'b000});
    ac(21, {8'h00, 3'b000});
    ac(28, {8'h00, 3'b000});
    ac(29, {8'h33, 3'b000});
    ac(47, {8'h10, 3'b000});
    repeat (3) @(posedge sys_clk_i);
    #1 check({osc_stop_o, power_down_o}, 2'b11);
    @(posedge sys_clk_i);
    wake_i <= 1'b1;
    @(posedge sys_clk_i);
    wake_i <= 1'b0;
    at(49);
    check(osc_stop_o, 1'b0);
    check(mem.dm[7'h40], 8'hfe);
    check(mem.dm[7'h41], 8'h81);
    check(mem.dm[7'h42], 8'h80);
    reg_xfer(1'b0, `MIE_REG_STATUS, 8'h08);
    reg_xfer(1'b0, 2'h2, 8'h00);
    reg_xfer(1'b1, `MIE_REG_STATUS, 8'h00);
    reg_xfer(1'b0, `MIE_REG_STATUS, 8'h00);
    reg_xfer(1'b1, `MIE_REG_CTRL, 8'h01);
    reg_xfer(1'b0, `MIE_REG_CTRL, 8'h01);
    @(posedge sys_clk_i);
    irq_req_i <= 1'b1;
    at(`MIE_IRQ_VEC);
    check(gie_o, 1'b0);
    @(posedge sys_clk_i);
    irq_req_i <= 1'b0;
    at(49);
    check(gie_o, 1'b1);
    give_verdict();
  end
endmodule : mie_core_tb
